// ==== inc/apt_pkg.sv ====
// Shared constants for the converter pair trigger control block
package apt_pkg;
  localparam int NUM_PAIRS = 4;
  localparam int SEL_W     = 5;
  // Register byte addresses
  localparam logic [7:0] OFF_PAIR01 = 8'h00;
  localparam logic [7:0] OFF_PAIR23 = 8'h04;
  localparam logic [7:0] OFF_GLBSW  = 8'h08;
  localparam logic [7:0] OFF_ISTAT  = 8'h0c;
  localparam logic [7:0] OFF_IMASK  = 8'h10;
  localparam logic [7:0] OFF_BUSY   = 8'h14;
  // Field layout inside one pair byte; upper pair sits 8 bits higher
  localparam int POS_SEL    = 0;
  localparam int POS_SOFT   = 5;
  localparam int POS_PEND   = 6;
  localparam int POS_IRQEN  = 7;
  localparam int PAIR_SHIFT = 8;
  localparam int POS_GLBSW  = 0;
  // Reset values
  localparam logic [15:0] RST_PAIR_CTRL = 16'h0000;
  localparam logic [3:0]  RST_IMASK     = 4'h0;
  // Trigger source codes
  localparam logic [4:0] SRC_OFF     = 5'h00;
  localparam logic [4:0] SRC_SW_IND  = 5'h01;
  localparam logic [4:0] SRC_SW_GLB  = 5'h02;
  localparam logic [4:0] SRC_SPECIAL = 5'h03;
  localparam logic [4:0] SRC_GEN1    = 5'h04;
  localparam logic [4:0] SRC_TMR1    = 5'h0c;
  localparam logic [4:0] SRC_TMR2    = 5'h0d;
  localparam logic [4:0] SRC_CL1     = 5'h0e;
  localparam logic [4:0] SRC_FLT1    = 5'h16;
endpackage : apt_pkg

// ==== design/apt_trig_mux.sv ====
// Trigger source selection for one converter pair
`timescale 1ns/1ps
`default_nettype none
module apt_trig_mux (
  input  wire logic [4:0] sel,
  input  wire logic       soft_ind,
  input  wire logic       soft_glb,
  input  wire logic       special,
  input  wire logic [3:0] gen,
  input  wire logic       tmr1,
  input  wire logic       tmr2,
  input  wire logic [3:0] cl,
  input  wire logic [3:0] flt,
  output logic            hit
);
  logic [31:0] src_vec;

  // Source table indexed by selector code; unused codes stay low
  always_comb
  begin
    src_vec = 32'h0000_0000;
    src_vec[apt_pkg::SRC_OFF] = 1'b0;
    src_vec[apt_pkg::SRC_SW_IND] = soft_ind;
    src_vec[apt_pkg::SRC_SW_GLB] = soft_glb;
    src_vec[apt_pkg::SRC_SPECIAL] = special;
    for (int k = 0; k < 4; k++)
    begin
      src_vec[apt_pkg::SRC_GEN1 + k] = gen[k];
      src_vec[apt_pkg::SRC_CL1 + k]  = cl[k];
      src_vec[apt_pkg::SRC_FLT1 + k] = flt[k];
    end
    src_vec[apt_pkg::SRC_TMR1] = tmr1;
    src_vec[apt_pkg::SRC_TMR2] = tmr2;
  end

  assign hit = src_vec[sel];
endmodule : apt_trig_mux
`default_nettype wire

// ==== design/apt_start_arb.sv ====
// Fixed-priority start issue for the shared conversion engine
`timescale 1ns/1ps
`default_nettype none
module apt_start_arb #(
  parameter int N = 4
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [N-1:0]       req,
  input  wire logic               free,
  output logic                    start,
  output logic [$clog2(N)-1:0]    start_pair
);
  logic [$clog2(N)-1:0] pick;
  logic                 any_req;
  logic                 start_next;

  // Lowest pair index wins; a steady source can starve higher ones
  always_comb
  begin
    pick = '0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (req[k])
      begin
        pick = k[$clog2(N)-1:0];
      end
    end
  end

  assign any_req    = |req;
  // Never two starts back to back; the issued flag needs a cycle to show
  assign start_next = any_req & free & ~start;

  // Registered start pulse and pair number
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      start      <= 1'b0;
      start_pair <= '0;
    end
    else
    begin
      start <= start_next;
      if (start_next)
      begin
        start_pair <= pick;
      end
    end
  end
endmodule : apt_start_arb
`default_nettype wire

// ==== design/apt_pair_trigger_ctrl.sv ====
// Converter pair trigger control with APB registers and interrupt
// Summary of operation
// - Each pair has a 5-bit source selector; zero disables that pair.
// - Code 1 picks the pair's own soft trigger, code 2 the global one.
// - Code 3 picks special event, codes 4 to 7 generators 1 to 4.
// - Codes 0x0c and 0x0d pick timer 1 and timer 2 period matches.
// - Codes 0x0e to 0x11 pick generator current-limit triggers 1 to 4.
// - Codes 0x16 to 0x19 pick generator fault triggers 1 to 4.
// - Pair 3 selector sits in bits 12-8 of second control register.
// - Pair 3 enable at bit 15 gates its completion interrupt request.
// - Pair 3 pending at bit 14 sets on trigger, clears on completion.
// - Pair 3 soft trigger at bit 13 clears when pending sets under code 1.
// - Busy engine keeps request pending until it frees.
// - Pair 2 enable at bit 7 gates its completion interrupt request.
`timescale 1ns/1ps
`default_nettype none
module apt_pair_trigger_ctrl #(
  parameter int NP = apt_pkg::NUM_PAIRS
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          pwm_special_event,
  input  wire logic [3:0]    pwm_gen_trig,
  input  wire logic          timer1_match,
  input  wire logic          timer2_match,
  input  wire logic [3:0]    pwm_cl_trig,
  input  wire logic [3:0]    pwm_fault_trig,
  input  wire logic          conv_busy,
  input  wire logic          conv_done,
  input  wire logic [1:0]    conv_done_pair,
  output logic               conv_start,
  output logic [1:0]         conv_pair,
  output logic [NP-1:0]      pair_pending,
  output logic               irq
);
  // Per-pair control state
  logic [4:0]    sel_reg     [NP];
  logic [NP-1:0] irq_en_reg;
  logic [NP-1:0] soft_reg;
  logic [NP-1:0] pending_reg;
  logic [NP-1:0] issued_reg;
  logic [NP-1:0] istat_reg;
  logic [NP-1:0] imask_reg;
  logic [31:0]   prdata_reg;
  logic          pslverr_reg;
  logic [NP-1:0] istat_set;
  logic [NP-1:0] istat_clr;

  // Per-pair combinational terms
  logic [NP-1:0] hit;
  logic [NP-1:0] done_hit;
  logic [NP-1:0] take;
  logic [NP-1:0] start_hit;
  logic [NP-1:0] wait_req;
  logic [15:0]   pair_byte01;
  logic [15:0]   pair_byte23;
  logic [7:0]    pair_byte [NP];

  // Bus decode
  logic          setup_ph;
  logic          wr_acc;
  logic          sel_p01;
  logic          sel_p23;
  logic          sel_glb;
  logic          sel_istat;
  logic          sel_imask;
  logic          sel_busy;
  logic          mapped;
  logic          glb_sw;
  logic [31:0]   rd_mux;
  logic [31:0]   rd_pair01;
  logic [31:0]   rd_pair23;
  logic [31:0]   rd_istat;
  logic [31:0]   rd_imask;
  logic [31:0]   rd_busy;
  logic          engine_free;

  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite;
  assign sel_p01   = (paddr == apt_pkg::OFF_PAIR01);
  assign sel_p23   = (paddr == apt_pkg::OFF_PAIR23);
  assign sel_glb   = (paddr == apt_pkg::OFF_GLBSW);
  assign sel_istat = (paddr == apt_pkg::OFF_ISTAT);
  assign sel_imask = (paddr == apt_pkg::OFF_IMASK);
  assign sel_busy  = (paddr == apt_pkg::OFF_BUSY);
  assign mapped    = sel_p01 | sel_p23 | sel_glb | sel_istat | sel_imask | sel_busy;

  // Global soft trigger is a one-cycle pulse, nothing is stored
  assign glb_sw = wr_acc & sel_glb & pwdata[apt_pkg::POS_GLBSW];

  // Slave answers in the first access cycle, no wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // engine counts as free only when idle and nothing issued
  assign engine_free = ~conv_busy & ~(|issued_reg);

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pair
      localparam int BASE = (gi % 2) * apt_pkg::PAIR_SHIFT;
      logic       wr_this;
      logic [4:0] wr_sel;
      logic       wr_irq_en;
      logic       wr_soft;
      logic       soft_set;
      logic       soft_clr;

      assign wr_this = wr_acc & ((gi < 2) ? sel_p01 : sel_p23);
      // Fields of this pair's byte in the write word
      assign wr_sel    = pwdata[BASE + apt_pkg::POS_SEL +: apt_pkg::SEL_W];
      assign wr_irq_en = pwdata[BASE + apt_pkg::POS_IRQEN];
      assign wr_soft   = pwdata[BASE + apt_pkg::POS_SOFT];
      // hardware clear wins over a software set
      assign soft_clr  = take[gi] & (sel_reg[gi] == apt_pkg::SRC_SW_IND);
      assign soft_set  = wr_this & wr_soft;

      apt_trig_mux u_mux (
        .sel      (sel_reg[gi]),
        .soft_ind (soft_reg[gi]),
        .soft_glb (glb_sw),
        .special  (pwm_special_event),
        .gen      (pwm_gen_trig),
        .tmr1     (timer1_match),
        .tmr2     (timer2_match),
        .cl       (pwm_cl_trig),
        .flt      (pwm_fault_trig),
        .hit      (hit[gi])
      );

      assign done_hit[gi]  = conv_done & (conv_done_pair == 2'(gi));
      // trigger only counts when no pending period remains
      assign take[gi]      = hit[gi] & (~pending_reg[gi] | done_hit[gi]);
      assign start_hit[gi] = conv_start & (conv_pair == 2'(gi));
      // pending but not yet handed to the engine
      assign wait_req[gi]  = pending_reg[gi] & ~issued_reg[gi];

      assign pair_byte[gi] = {irq_en_reg[gi], pending_reg[gi], soft_reg[gi], sel_reg[gi]};

      // status set by done of an issued, enabled pair
      assign istat_set[gi] = done_hit[gi] & issued_reg[gi] & irq_en_reg[gi];
      assign istat_clr[gi] = wr_acc & sel_istat & pwdata[gi];

      // Selector and enable, written by software
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          sel_reg[gi]    <= apt_pkg::RST_PAIR_CTRL[4:0];
          irq_en_reg[gi] <= apt_pkg::RST_PAIR_CTRL[apt_pkg::POS_IRQEN];
        end
        else if (wr_this)
        begin
          // selector field of the addressed pair byte
          sel_reg[gi]    <= wr_sel;
          irq_en_reg[gi] <= wr_irq_en;
        end
      end

      // Soft trigger request bit
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          soft_reg[gi] <= apt_pkg::RST_PAIR_CTRL[apt_pkg::POS_SOFT];
        end
        // hardware clear once pending is taken
        else if (soft_clr)
        begin
          soft_reg[gi] <= 1'b0;
        end
        else if (soft_set)
        begin
          soft_reg[gi] <= 1'b1;
        end
      end

      // Pending flag; a new trigger wins over a completion
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          pending_reg[gi] <= apt_pkg::RST_PAIR_CTRL[apt_pkg::POS_PEND];
        end
        else if (take[gi])
        begin
          pending_reg[gi] <= 1'b1;
        end
        else if (done_hit[gi])
        begin
          pending_reg[gi] <= 1'b0;
        end
      end

      // Handed to engine; next request of this pair waits for done
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          issued_reg[gi] <= 1'b0;
        end
        else if (start_hit[gi])
        begin
          issued_reg[gi] <= 1'b1;
        end
        else if (done_hit[gi])
        begin
          issued_reg[gi] <= 1'b0;
        end
      end

      // Sticky completion status; the set wins over a W1C clear
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          istat_reg[gi] <= 1'b0;
        end
        // only enabled pairs raise a request
        else if (istat_set[gi])
        begin
          istat_reg[gi] <= 1'b1;
        end
        else if (istat_clr[gi])
        begin
          istat_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      imask_reg <= apt_pkg::RST_IMASK;
    end
    else if (wr_acc && sel_imask)
    begin
      imask_reg <= pwdata[NP-1:0];
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(istat_reg & imask_reg);

  assign pair_pending = pending_reg;
  assign pair_byte01  = {pair_byte[1], pair_byte[0]};
  assign pair_byte23  = {pair_byte[3], pair_byte[2]};

  // Register read words; unused bits read zero
  assign rd_pair01 = {16'h0000, pair_byte01};
  assign rd_pair23 = {16'h0000, pair_byte23};
  assign rd_istat  = {{(32 - NP){1'b0}}, istat_reg};
  assign rd_imask  = {{(32 - NP){1'b0}}, imask_reg};
  assign rd_busy   = {{(32 - NP){1'b0}}, issued_reg};

  // Read data selection; unmapped addresses read zero
  assign rd_mux = sel_p01   ? rd_pair01 :
                  sel_p23   ? rd_pair23 :
                  sel_istat ? rd_istat :
                  sel_imask ? rd_imask :
                  sel_busy  ? rd_busy :
                  32'h0000_0000;

  // Read data and error captured in setup, held through access
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end

  // start waiting pairs once the engine is free
  apt_start_arb #(
    .N (NP)
  ) u_arb (
    .clk        (clk),
    .rstn       (rstn),
    .req        (wait_req),
    .free       (engine_free),
    .start      (conv_start),
    .start_pair (conv_pair)
  );
endmodule : apt_pair_trigger_ctrl
`default_nettype wire

// ==== dv/apt_chk.sv ====
// Port assertions for the pair trigger control
`timescale 1ns/1ps
`default_nettype none
module apt_chk (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       conv_busy,
  input wire logic       conv_done,
  input wire logic [1:0] conv_done_pair,
  input wire logic       conv_start,
  input wire logic [1:0] conv_pair,
  input wire logic [3:0] pair_pending,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Bus answer and reset state
  AST_READY: assert property (psel && penable |-> pready)
    else $error("no ready in access");
  AST_ERR_MAP: assert property (psel && !penable && paddr[1:0] == 2'b00 |=> pslverr == ($past(paddr) > 8'h14))
    else $error("wrong slave error");
  AST_RESET_IDLE: assert property ($rose(rstn) |-> !irq && !conv_start && pair_pending == 4'h0)
    else $error("not idle after reset");
  // Issue waits for a free engine and one outstanding job
  AST_ONE_OUT: assert property (conv_start |=> !conv_start until conv_done)
    else $error("second start before done");
  AST_START_PEND: assert property (conv_start |-> pair_pending[conv_pair])
    else $error("start without pending");
  AST_BUSY_HOLD: assert property (conv_start |-> $past(!conv_busy))
    else $error("start while engine busy");
  AST_START_SOON: assert property ($rose(pair_pending[3]) && pair_pending[2:0] == 3'b000 && !conv_busy
    |=> conv_start && conv_pair == 2'd3)
    else $error("free engine left idle");
  // Completion side effects
  AST_PEND_FALL: assert property ($past(rstn) && $fell(pair_pending[3])
    |-> $past(conv_done && conv_done_pair == 2'd3))
    else $error("pending cleared without done");
  AST_IRQ_CAUSE: assert property ($past(rstn) && $rose(irq) |-> $past(conv_done || pwrite && penable))
    else $error("interrupt without cause");
  COV_START3: cover property (conv_start && conv_pair == 2'd3);
  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (pslverr);
endmodule : apt_chk
`default_nettype wire

// ==== dv/apt_engine_model.sv ====
// Behavioural shared conversion engine
`timescale 1ns/1ps
`default_nettype none
module apt_engine_model #(
  parameter int LAT = 6
) (
  input  wire logic       clk,
  input  wire logic       hold_busy,
  input  wire logic       conv_start,
  input  wire logic [1:0] conv_pair,
  output logic            conv_busy,
  output logic            conv_done,
  output logic [1:0]      conv_done_pair
);
  int         cnt = 0;
  logic [1:0] cur = 2'h0;
  // Other work holds the engine while the bench asks
  assign conv_busy = hold_busy;
  // Done after a fixed time; pair code is junk outside done
  always @(posedge clk)
  begin
    conv_done <= 1'b0;
    conv_done_pair <= ~cur;
    if (conv_start)
    begin
      cur <= conv_pair;
      cnt <= LAT;
    end
    else if (cnt == 1)
    begin
      conv_done <= 1'b1;
      conv_done_pair <= cur;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : apt_engine_model
`default_nettype wire

// ==== dv/test_adc_pair_trigger_control.sv ====
// Self-checking bench for the pair trigger control
`timescale 1ns/1ps
`default_nettype none
module test_adc_pair_trigger_control;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [14:0] trig = 15'h0;
  logic        hold_busy = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, rerr, conv_busy, conv_done, conv_start, irq;
  logic [1:0]  conv_done_pair, conv_pair;
  logic [3:0]  pair_pending;
  int          error_cnt = 0;
  int          checked = 0;
  int          starts = 0;
  int          s0;
  // Bench order: special, gen 1-4, timers 1-2, limit 1-4, fault 1-4
  localparam logic [4:0] CODES [15] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d,
    5'h0e, 5'h0f, 5'h10, 5'h11, 5'h16, 5'h17, 5'h18, 5'h19};
  apt_pair_trigger_ctrl u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_special_event(trig[0]), .pwm_gen_trig(trig[4:1]), .timer1_match(trig[5]), .timer2_match(trig[6]),
    .pwm_cl_trig(trig[10:7]), .pwm_fault_trig(trig[14:11]), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_done_pair(conv_done_pair), .conv_start(conv_start), .conv_pair(conv_pair),
    .pair_pending(pair_pending), .irq(irq));
  apt_engine_model u_eng (.clk(clk), .hold_busy(hold_busy), .conv_start(conv_start), .conv_pair(conv_pair),
    .conv_busy(conv_busy), .conv_done(conv_done), .conv_done_pair(conv_done_pair));
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Count issued conversions
  always @(posedge clk)
    if (conv_start === 1'b1)
      starts++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Setup then access; request held until ready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // A wait that runs out counts as a mismatch
    chk(pready, 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic pulse(input logic [14:0] v);
    trig <= v;
    @(posedge clk);
    trig <= 15'h0;
    @(posedge clk);
  endtask : pulse
  // Flags are polled with a bound, a hang shows as a mismatch
  task automatic wait_pend(input int p, input logic v);
    int n;
    n = 0;
    while (pair_pending[p] !== v && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk(pair_pending[p], v);
  endtask : wait_pend
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Watchdog, far above the few hundred cycles needed
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 15; i++)
    begin
      apb(1'b1, apt_pkg::OFF_PAIR23, {16'h0, 3'b100, CODES[i], 8'h00});
      pulse(~(15'h1 << i));
      chk(pair_pending, 4'h0);
      pulse(15'h1 << i);
      wait_pend(3, 1'b1);
      wait_pend(3, 1'b0);
      rdchk(apt_pkg::OFF_ISTAT, 32'h8);
      apb(1'b1, apt_pkg::OFF_ISTAT, 32'h8);
    end
    // Off and unused codes ignore every source
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'h0800);
    pulse(15'h7fff);
    chk(pair_pending, 4'h0);
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'h0000);
    pulse(15'h7fff);
    chk(pair_pending, 4'h0);
    // Pair 0 selector works like the others
    apb(1'b1, apt_pkg::OFF_PAIR01, 32'h0003);
    pulse(15'h1);
    wait_pend(0, 1'b1);
    wait_pend(0, 1'b0);
    apb(1'b1, apt_pkg::OFF_PAIR01, 32'h0000);
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'h2300);
    repeat (2) @(posedge clk);
    rdchk(apt_pkg::OFF_PAIR23, 32'h2300);
    // Soft request waits out a busy engine
    s0 = starts;
    hold_busy <= 1'b1;
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'ha100);
    wait_pend(3, 1'b1);
    repeat (8) @(posedge clk);
    chk(starts, s0);
    rdchk(apt_pkg::OFF_PAIR23, 32'hc100);
    rdchk(apt_pkg::OFF_BUSY, 32'h0);
    hold_busy <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(apt_pkg::OFF_BUSY, 32'h8);
    wait_pend(3, 1'b0);
    // Repeated triggers while pending give one conversion
    s0 = starts;
    hold_busy <= 1'b1;
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'h8300);
    repeat (3) pulse(15'h1);
    hold_busy <= 1'b0;
    wait_pend(3, 1'b0);
    repeat (12) @(posedge clk);
    chk(starts, s0 + 1);
    rdchk(apt_pkg::OFF_ISTAT, 32'h8);
    apb(1'b1, apt_pkg::OFF_IMASK, 32'h8);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, apt_pkg::OFF_ISTAT, 32'h8);
    @(posedge clk);
    chk(irq, 1'b0);
    // Global trigger on pairs 2 and 3, only pair 2 reports
    apb(1'b1, apt_pkg::OFF_PAIR23, 32'h0282);
    apb(1'b1, apt_pkg::OFF_GLBSW, 32'h1);
    wait_pend(3, 1'b1);
    chk(pair_pending, 4'hc);
    wait_pend(2, 1'b0);
    chk(pair_pending, 4'h8);
    wait_pend(3, 1'b0);
    rdchk(apt_pkg::OFF_ISTAT, 32'h4);
    // Mid-run reset restores defaults
    apb(1'b1, apt_pkg::OFF_PAIR01, 32'hffff);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(apt_pkg::OFF_PAIR01, 32'h0);
    rdchk(apt_pkg::OFF_PAIR23, 32'h0);
    rdchk(apt_pkg::OFF_ISTAT, 32'h0);
    rdchk(apt_pkg::OFF_IMASK, 32'h0);
    rdchk(8'h20, 32'h0);
    chk(rerr, 1'b1);
    print_verdict();
  end
endmodule : test_adc_pair_trigger_control
bind apt_pair_trigger_ctrl apt_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .conv_busy(conv_busy),
  .conv_done(conv_done), .conv_done_pair(conv_done_pair), .conv_start(conv_start), .conv_pair(conv_pair),
  .pair_pending(pair_pending), .irq(irq));
`default_nettype wire
